// ### hw/bridge_gpio_pkg.sv
// constants for the select-pin port and its small spi master
// assumes a 20 MHz core clock and commands already parsed from the bus
package bridge_gpio_pkg;

    localparam int          NPINS          = 4;
    localparam logic [7:0]  CMD_PIN_WRITE  = 8'hF4;
    localparam logic [7:0]  CMD_PIN_SAMPLE = 8'hF5;
    localparam logic [7:0]  CMD_PIN_ROLE   = 8'hF6;
    localparam logic [7:0]  CMD_PIN_TYPE   = 8'hF7;
    localparam logic [7:0]  CMD_XFER_MIN   = 8'h01;
    localparam logic [7:0]  CMD_XFER_MAX   = 8'h0F;

    localparam logic [1:0]  TYPE_QUASI     = 2'h0;
    localparam logic [1:0]  TYPE_PUSH      = 2'h1;
    localparam logic [1:0]  TYPE_INPUT     = 2'h2;
    localparam logic [1:0]  TYPE_OPEN      = 2'h3;
    localparam int          TYPE_FIELD_W   = 2;

    localparam logic [3:0]  LATCH_RST      = 4'h0;
    localparam logic [3:0]  ROLE_RST       = 4'h0;
    localparam logic [7:0]  TYPE_RST       = 8'h00;

    localparam int          CLK_KHZ        = 20000;
    localparam logic [1:0]  STRONG_CYCLES  = 2'h2;
    localparam int          FILTER_LEN     = 3;
    localparam int          EDGES_W        = 4;

    // bit rates per rate field, in kHz
    localparam int          RATE0_KHZ      = 1843;
    localparam int          RATE1_KHZ      = 461;
    localparam int          RATE2_KHZ      = 115;
    localparam int          RATE3_KHZ      = 58;
    // half periods round up so the bit rate never exceeds the figure
    localparam int HALF0 = (CLK_KHZ + 2 * RATE0_KHZ - 1) / (2 * RATE0_KHZ);
    localparam int HALF1 = (CLK_KHZ + 2 * RATE1_KHZ - 1) / (2 * RATE1_KHZ);
    localparam int HALF2 = (CLK_KHZ + 2 * RATE2_KHZ - 1) / (2 * RATE2_KHZ);
    localparam int HALF3 = (CLK_KHZ + 2 * RATE3_KHZ - 1) / (2 * RATE3_KHZ);
    localparam int          DIV_W          = 8;

    typedef enum logic [1:0] {XF_IDLE, XF_LOAD, XF_RUN, XF_END} xfer_state_t;

endpackage : bridge_gpio_pkg

// ### hw/bridge_gpio_port_control.sv
// select-pin port: gpio latches, drive types, pin filters, spi master
// assumes parsed commands from the bus side and a combinational buffer read
`timescale 1ns/1ps
module bridge_gpio_port_control
    import bridge_gpio_pkg::*;
#(
    parameter int FILTER_DEPTH = FILTER_LEN
)
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic       i_cmd_valid,
    input  wire logic [7:0] i_cmd_code,
    input  wire logic [7:0] i_cmd_data,
    input  wire logic [7:0] i_xfer_len,
    input  wire logic [1:0] i_spi_mode,
    input  wire logic [1:0] i_spi_rate,
    input  wire logic       i_spi_lsb_first,
    output logic            o_busy,
    output logic            o_buf_wr,
    output logic [7:0]      o_buf_wdata,
    output logic            o_tx_req,
    input  wire logic [7:0] i_tx_data,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    input  wire logic [3:0] i_sel_pin,
    output logic [3:0]      o_sel_pin_out,
    output logic [3:0]      o_sel_pin_oe_n,
    output logic [3:0]      o_pull_strong,
    output logic [3:0]      o_pull_weak,
    output logic [3:0]      o_pull_very_weak,
    output logic [3:0]      o_pull_down,
    output logic            o_serial_clock_out,
    output logic            o_mosi,
    input  wire logic       i_miso
);

    function automatic logic [DIV_W-1:0] half_cycles(input logic [1:0] r);
        case (r)
            2'h0:    return DIV_W'(HALF0 - 1);
            2'h1:    return DIV_W'(HALF1 - 1);
            2'h2:    return DIV_W'(HALF2 - 1);
            default: return DIV_W'(HALF3 - 1);
        endcase
    endfunction : half_cycles

    function automatic logic pick_bit(input logic [7:0] b,
                                      input logic [2:0] idx,
                                      input logic       lsb);
        return lsb ? b[idx] : b[3'h7 - idx];
    endfunction : pick_bit

    xfer_state_t            state_q;
    logic [3:0]             latch_q;
    logic [3:0]             latch_d;
    logic [3:0]             role_q;
    logic [7:0]             type_q;
    logic [1:0]             strong_cnt_q [NPINS];
    logic [3:0]             sync1_q;
    logic [3:0]             sync2_q;
    logic [FILTER_DEPTH-1:0] hist_q [NPINS];
    logic [3:0]             lvl_q;
    logic [3:0]             up_d;
    logic [3:0]             weak_d;
    logic [3:0]             vweak_d;
    logic [3:0]             down_d;
    logic [3:0]             strong_rise;
    logic [3:0]             sel_mask_q;
    logic [7:0]             bytes_left_q;
    logic [1:0]             mode_q;
    logic [1:0]             rate_q;
    logic                   lsb_q;
    logic [DIV_W-1:0]       div_q;
    logic [EDGES_W-1:0]     edge_q;
    logic [7:0]             tx_q;
    logic [7:0]             rx_q;
    logic [7:0]             rx_shift;
    logic                   miso_s1_q;
    logic                   miso_s2_q;
    logic                   tick;
    logic                   cmd_take;
    logic                   sample_edge;
    logic                   xfer_active;

    assign cmd_take    = i_cmd_valid && (state_q == XF_IDLE);
    assign tick        = (state_q == XF_RUN || state_q == XF_END)
                         && (div_q == '0);
    assign xfer_active = (state_q != XF_IDLE);
    // commands that arrive while busy are dropped
    // busy flag
    assign o_busy      = xfer_active;
    assign o_tx_req    = (state_q == XF_LOAD);

    always_comb
    begin
        latch_d = latch_q;
        if (cmd_take && i_cmd_code == CMD_PIN_WRITE)
            latch_d = (latch_q & ~role_q) | (i_cmd_data[3:0] & role_q);
    end

    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
            strong_rise[i] = latch_d[i] && !latch_q[i] && role_q[i]
                && type_q[TYPE_FIELD_W*i +: TYPE_FIELD_W] == TYPE_QUASI;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            latch_q <= LATCH_RST;
            role_q  <= ROLE_RST;
            type_q  <= TYPE_RST;
        end
        else
        begin
            latch_q <= latch_d;
            if (cmd_take && i_cmd_code == CMD_PIN_ROLE)
            begin
                role_q <= i_cmd_data[3:0];
                for (int i = 0; i < NPINS; i++)
                    if (i_cmd_data[i] && !role_q[i])
                        type_q[TYPE_FIELD_W*i +: TYPE_FIELD_W] <= TYPE_QUASI;
            end
            if (cmd_take && i_cmd_code == CMD_PIN_TYPE)
                type_q <= i_cmd_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < NPINS; i++)
                strong_cnt_q[i] <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < NPINS; i++)
                if (strong_rise[i])
                    strong_cnt_q[i] <= STRONG_CYCLES;
                else if (strong_cnt_q[i] != 2'h0)
                    strong_cnt_q[i] <= strong_cnt_q[i] - 2'h1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            lvl_q   <= 4'h0;
            for (int i = 0; i < NPINS; i++)
                hist_q[i] <= '0;
        end
        else
        begin
            sync1_q <= i_sel_pin;
            sync2_q <= sync1_q;
            for (int i = 0; i < NPINS; i++)
            begin
                hist_q[i] <= {hist_q[i][FILTER_DEPTH-2:0], sync2_q[i]};
                // level moves only after a full run of equal samples
                if (&hist_q[i])
                    lvl_q[i] <= 1'b1;
                else if (~|hist_q[i])
                    lvl_q[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_buf_wr    <= 1'b0;
            o_buf_wdata <= 8'h00;
        end
        else
        begin
            o_buf_wr <= cmd_take && i_cmd_code == CMD_PIN_SAMPLE;
            if (cmd_take && i_cmd_code == CMD_PIN_SAMPLE)
                o_buf_wdata <= {4'h0, lvl_q};
        end
    end

    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
        begin
            up_d[i]    = 1'b0;
            weak_d[i]  = 1'b0;
            vweak_d[i] = 1'b0;
            down_d[i]  = 1'b0;
            if (role_q[i])
            begin
                unique case (type_q[TYPE_FIELD_W*i +: TYPE_FIELD_W])
                    TYPE_QUASI:
                    begin
                        vweak_d[i] = latch_q[i];
                        weak_d[i]  = latch_q[i] && lvl_q[i];
                        // boost never fights the pull-down
                        up_d[i]    = (strong_cnt_q[i] != 2'h0)
                                     && latch_q[i];
                        down_d[i]  = !latch_q[i];
                    end
                    TYPE_PUSH:
                    begin
                        up_d[i]   = latch_q[i];
                        down_d[i] = !latch_q[i];
                    end
                    TYPE_OPEN:
                        down_d[i] = !latch_q[i];
                    TYPE_INPUT:
                        down_d[i] = 1'b0;
                endcase
            end
            else
            begin
                down_d[i] = xfer_active && sel_mask_q[i];
                up_d[i]   = !down_d[i];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_pull_strong    <= 4'hF;
            o_pull_weak      <= 4'h0;
            o_pull_very_weak <= 4'h0;
            o_pull_down      <= 4'h0;
            o_sel_pin_out    <= 4'hF;
            o_sel_pin_oe_n   <= 4'h0;
        end
        else
        begin
            o_pull_strong    <= up_d;
            o_pull_weak      <= weak_d;
            o_pull_very_weak <= vweak_d;
            o_pull_down      <= down_d;
            o_sel_pin_out    <= up_d & ~down_d;
            o_sel_pin_oe_n   <= ~(up_d | down_d);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end
        else
        begin
            miso_s1_q <= i_miso;
            miso_s2_q <= miso_s1_q;
        end
    end

    assign sample_edge = (edge_q[0] == mode_q[0]);
    assign rx_shift    = lsb_q ? {miso_s2_q, rx_q[7:1]}
                               : {rx_q[6:0], miso_s2_q};

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q      <= XF_IDLE;
            sel_mask_q   <= 4'h0;
            bytes_left_q <= 8'h00;
            mode_q       <= 2'h0;
            rate_q       <= 2'h0;
            lsb_q        <= 1'b0;
            div_q        <= '0;
            edge_q       <= '0;
            tx_q         <= 8'h00;
            rx_q         <= 8'h00;
            o_rx_valid   <= 1'b0;
            o_rx_data    <= 8'h00;
            o_mosi       <= 1'b0;
            o_serial_clock_out <= 1'b0;
        end
        else
        begin
            o_rx_valid <= 1'b0;
            if (tick)
                div_q <= half_cycles(rate_q);
            else if (div_q != '0)
                div_q <= div_q - DIV_W'(1);
            unique case (state_q)
                XF_IDLE:
                begin
                    o_serial_clock_out <= mode_q[1];
                    if (cmd_take && i_cmd_code >= CMD_XFER_MIN
                        && i_cmd_code <= CMD_XFER_MAX && i_xfer_len != 8'h00)
                    begin
                        sel_mask_q   <= i_cmd_code[3:0];
                        bytes_left_q <= i_xfer_len;
                        mode_q       <= i_spi_mode;
                        rate_q       <= i_spi_rate;
                        lsb_q        <= i_spi_lsb_first;
                        o_serial_clock_out <= i_spi_mode[1];
                        state_q      <= XF_LOAD;
                    end
                end
                XF_LOAD:
                begin
                    tx_q   <= i_tx_data;
                    edge_q <= '0;
                    div_q  <= half_cycles(rate_q);
                    // first bit must stand before the leading edge
                    if (!mode_q[0])
                        o_mosi <= pick_bit(i_tx_data, 3'h0, lsb_q);
                    state_q <= XF_RUN;
                end
                XF_RUN:
                begin
                    if (tick)
                    begin
                        o_serial_clock_out <= ~o_serial_clock_out;
                        edge_q <= edge_q + EDGES_W'(1);
                        if (sample_edge)
                            rx_q <= rx_shift;
                        if (mode_q[0] && !edge_q[0])
                            o_mosi <= pick_bit(tx_q, edge_q[3:1], lsb_q);
                        else if (!mode_q[0] && edge_q[0] && edge_q[3:1] != 3'h7)
                            o_mosi <= pick_bit(tx_q, edge_q[3:1] + 3'h1,
                                               lsb_q);
                        if (edge_q == {EDGES_W{1'b1}})
                        begin
                            o_rx_valid   <= 1'b1;
                            o_rx_data    <= sample_edge ? rx_shift : rx_q;
                            bytes_left_q <= bytes_left_q - 8'h01;
                            state_q <= (bytes_left_q == 8'h01) ? XF_END
                                                               : XF_LOAD;
                        end
                    end
                end
                XF_END:
                    if (tick)
                        state_q <= XF_IDLE;
            endcase
        end
    end

    property p_latch_write;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (cmd_take && i_cmd_code == CMD_PIN_WRITE) |=>
            latch_q == (($past(latch_q) & ~$past(role_q))
                        | ($past(i_cmd_data[3:0]) & $past(role_q)));
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("pin latch write wrong");

    property p_sample;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (cmd_take && i_cmd_code == CMD_PIN_SAMPLE) |=>
            o_buf_wr && o_buf_wdata[3:0] == $past(lvl_q);
    endproperty
    a_sample: assert property (p_sample)
        else $error("sample byte not written");

    property p_new_quasi;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (cmd_take && i_cmd_code == CMD_PIN_ROLE && i_cmd_data[0]
         && !role_q[0]) |=> type_q[1:0] == TYPE_QUASI && role_q[0];
    endproperty
    a_new_quasi: assert property (p_new_quasi)
        else $error("new gpio pin not quasi");

    property p_strong_two;
        @(posedge i_mclk) disable iff (!i_rst_n)
        strong_rise[0] ##1 (!i_cmd_valid) [*3] |->
            $past(o_pull_strong[0]) && o_pull_strong[0]
            ##1 !o_pull_strong[0];
    endproperty
    a_strong_two: assert property (p_strong_two)
        else $error("strong pull-up not two cycles");

    property p_weak_drop;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (role_q[0] && type_q[1:0] == TYPE_QUASI && !lvl_q[0])
            |=> !o_pull_weak[0];
    endproperty
    a_weak_drop: assert property (p_weak_drop)
        else $error("weak pull-up on with pin low");

    property p_quasi_low;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (role_q[0] && type_q[1:0] == TYPE_QUASI && !latch_q[0])
            |=> o_pull_down[0] && !o_sel_pin_oe_n[0] && !o_sel_pin_out[0];
    endproperty
    a_quasi_low: assert property (p_quasi_low)
        else $error("quasi pin not driven low");

    property p_open_noup;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (role_q[0] && type_q[1:0] == TYPE_OPEN) |=>
            !o_pull_strong[0] && !o_pull_weak[0] && !o_pull_very_weak[0];
    endproperty
    a_open_noup: assert property (p_open_noup)
        else $error("open-drain pin has pull-up");

    property p_push_high;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (role_q[0] && type_q[1:0] == TYPE_PUSH && latch_q[0])
            |=> o_pull_strong[0] && !o_pull_down[0];
    endproperty
    a_push_high: assert property (p_push_high)
        else $error("push-pull pin not high");

    property p_select_low;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!role_q[0] && xfer_active && sel_mask_q[0])
            |=> o_pull_down[0] && !o_sel_pin_out[0];
    endproperty
    a_select_low: assert property (p_select_low)
        else $error("select not low in transfer");

    property p_rate;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (tick && state_q == XF_RUN) |=> !tick [*5];
    endproperty
    a_rate: assert property (p_rate)
        else $error("spi clock edges too close");

endmodule : bridge_gpio_port_control

// ### testbench/gpio_far_side.sv
// far side of the select pins: board wiring plus a loopback spi slave
// assumes a board pull-up on every pin and the slave selected while busy
`timescale 1ns/1ps
module gpio_far_side (
    input  wire logic       i_mclk,
    input  wire logic [3:0] i_pull_down,
    input  wire logic [3:0] i_ext_low,
    input  wire logic       i_slave_sel,
    input  wire logic       i_mosi,
    output logic [3:0]      o_pin,
    output logic            o_miso
);
    logic tgl_q = 1'b0;

    // pin level
    // an outside low overpowers weak and very weak pull-ups
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            o_pin[i] = !(i_pull_down[i] || i_ext_low[i]);
        end
    end

    // released miso must not look like stale data
    always_ff @(posedge i_mclk)
    begin
        tgl_q <= !tgl_q;
    end

    // selected slave echoes mosi, so received byte equals sent byte
    assign o_miso = i_slave_sel ? i_mosi : tgl_q;
endmodule : gpio_far_side

// ### testbench/test_bridge_gpio_port_control.sv
// self-checking bench for the select-pin port
// assumes the far-side model and commands handed over one at a time
`timescale 1ns/1ps
module test_bridge_gpio_port_control;
    import bridge_gpio_pkg::*;
    logic       i_mclk, i_rst_n, i_cmd_valid, i_miso, i_spi_lsb_first;
    logic [7:0] i_cmd_code, i_cmd_data, i_xfer_len, i_tx_data;
    logic [1:0] i_spi_mode, i_spi_rate;
    logic [3:0] i_sel_pin, ext_low;
    logic       o_busy, o_buf_wr, o_tx_req, o_rx_valid, o_sclk, o_mosi;
    logic [7:0] o_buf_wdata, o_rx_data;
    logic [3:0] o_out, o_oe_n, o_strong, o_weak, o_vweak, o_down;
    int         failures, checks, rises, n;
    localparam logic [3:0] STRONG_EXP = 4'h2;
    localparam logic [3:0] VWEAK_EXP  = 4'h1;
    localparam logic [3:0] DOWN_EXP   = 4'hB;
    localparam logic [3:0] OE_N_EXP   = 4'hD;

    bridge_gpio_port_control i_dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
        .i_cmd_code(i_cmd_code), .i_cmd_data(i_cmd_data),
        .i_xfer_len(i_xfer_len), .i_spi_mode(i_spi_mode),
        .i_spi_rate(i_spi_rate), .i_spi_lsb_first(i_spi_lsb_first),
        .o_busy(o_busy), .o_buf_wr(o_buf_wr), .o_buf_wdata(o_buf_wdata),
        .o_tx_req(o_tx_req), .i_tx_data(i_tx_data),
        .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
        .i_sel_pin(i_sel_pin), .o_sel_pin_out(o_out),
        .o_sel_pin_oe_n(o_oe_n), .o_pull_strong(o_strong),
        .o_pull_weak(o_weak), .o_pull_very_weak(o_vweak),
        .o_pull_down(o_down), .o_serial_clock_out(o_sclk),
        .o_mosi(o_mosi), .i_miso(i_miso));

    gpio_far_side i_far (
        .i_mclk(i_mclk), .i_pull_down(o_down), .i_ext_low(ext_low),
        .i_slave_sel(o_busy), .i_mosi(o_mosi), .o_pin(i_sel_pin),
        .o_miso(i_miso));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // returns in the cycle after the taking edge
    task automatic cmd(input logic [7:0] code, input logic [7:0] data,
                       input logic [7:0] len);
        @(posedge i_mclk);
        i_cmd_valid <= 1'b1;
        i_cmd_code  <= code;
        i_cmd_data  <= data;
        i_xfer_len  <= len;
        @(posedge i_mclk);
        i_cmd_valid <= 1'b0;
        #1;
    endtask : cmd

    task automatic cyc(input int k);
        repeat (k) @(posedge i_mclk);
        #1;
    endtask : cyc

    task automatic end_sim;
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        i_mclk = 1'b0;
        forever #25 i_mclk = !i_mclk;
    end

    always @(posedge o_sclk)
    begin
        if (o_busy === 1'b1)
            rises++;
    end

    initial
    begin
        repeat (5000) @(posedge i_mclk);
        failures++;
        end_sim();
    end

    initial
    begin
        failures = 0; checks = 0; rises = 0;
        i_rst_n = 1'b0; i_cmd_valid = 1'b0; i_cmd_code = 8'h00;
        i_cmd_data = 8'h00; i_xfer_len = 8'h00; i_spi_mode = 2'h0;
        i_spi_rate = 2'h0; i_spi_lsb_first = 1'b0; i_tx_data = 8'hA5;
        ext_low = 4'h0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        cyc(1);
        chk({4'h0, o_strong}, 8'h0F);
        chk({4'h0, o_down}, 8'h00);
        chk({o_out, o_oe_n}, 8'hF0);
        cmd(CMD_PIN_WRITE, 8'h0F, 8'h00);
        cyc(2);
        chk({4'h0, o_down}, 8'h00);
        cmd(CMD_PIN_ROLE, 8'h03, 8'h00);
        cyc(2);
        chk({4'h0, o_down}, 8'h03);
        chk({4'h0, o_strong}, 8'h0C);
        cmd(CMD_PIN_WRITE, 8'hF1, 8'h00);
        cyc(1);
        chk({7'h0, o_strong[0]}, 8'h01);
        cyc(1);
        chk({7'h0, o_strong[0]}, 8'h01);
        cyc(1);
        chk({7'h0, o_strong[0]}, 8'h00);
        chk({6'h0, o_vweak[1:0]}, 8'h01);
        chk({6'h0, o_down[1:0]}, 8'h02);
        cyc(8);
        chk({7'h0, o_weak[0]}, 8'h01);
        // byte read back right after each sample
        cmd(CMD_PIN_SAMPLE, 8'h00, 8'h00);
        chk({7'h0, o_buf_wr}, 8'h01);
        chk({6'h0, o_buf_wdata[1:0]}, 8'h01);
        ext_low <= 4'h1;
        cyc(8);
        chk({6'h0, o_weak[0], o_vweak[0]}, 8'h01);
        // the byte changes only on a sample command, then holds while the pin moves
        cmd(CMD_PIN_SAMPLE, 8'h00, 8'h00);
        chk({6'h0, o_buf_wdata[1:0]}, 8'h00);
        ext_low <= 4'h0;
        cyc(8);
        chk({6'h0, o_buf_wdata[1:0]}, 8'h00);
        for (int t = 0; t < 4; t++)
        begin
            cmd(CMD_PIN_TYPE, {4'h0, t[1:0], t[1:0]}, 8'h00);
            cyc(4);
            chk({7'h0, o_strong[0]}, {7'h0, STRONG_EXP[t]});
            chk({7'h0, o_vweak[0]}, {7'h0, VWEAK_EXP[t]});
            chk({7'h0, o_down[1]}, {7'h0, DOWN_EXP[t]});
            chk({7'h0, o_oe_n[0]}, {7'h0, OE_N_EXP[t]});
        end
        cmd(CMD_PIN_ROLE, 8'h00, 8'h00);
        cyc(2);
        cmd(8'h05, 8'h00, 8'h01);
        chk({7'h0, o_tx_req}, 8'h01);
        cyc(1);
        chk({4'h0, o_down}, 8'h05);
        cmd(CMD_PIN_ROLE, 8'h0F, 8'h00);
        n = 0;
        while (n < 400 && o_rx_valid !== 1'b1)
        begin
            cyc(1);
            n++;
        end
        chk({7'h0, o_rx_valid}, 8'h01);
        chk(o_rx_data, 8'hA5);
        n = 0;
        while (n < 100 && o_busy !== 1'b0)
        begin
            cyc(1);
            n++;
        end
        cyc(2);
        chk({4'h0, o_strong, o_down}, 8'hF0);
        chk(rises[7:0], 8'h08);
        // idle-high clock, late phase, lsb first, second rate
        i_spi_mode      <= 2'h3;
        i_spi_rate      <= 2'h1;
        i_spi_lsb_first <= 1'b1;
        i_tx_data       <= 8'h3C;
        cmd(8'h08, 8'h00, 8'h01);
        chk({7'h0, o_tx_req}, 8'h01);
        cyc(1);
        chk({4'h0, o_down}, 8'h08);
        n = 0;
        while (n < 500 && o_busy !== 1'b0)
        begin
            cyc(1);
            n++;
        end
        chk({7'h0, o_busy}, 8'h00);
        chk(o_rx_data, 8'h3C);
        chk({7'h0, o_sclk}, 8'h01);
        end_sim();
    end
endmodule : test_bridge_gpio_port_control
